// ===== logic/brs_pkg.sv
// types shared by the boot rom select block
// assumes the constants header is compiled alongside
package brs_pkg;
  typedef enum logic [1:0] {brs_tgt_none, brs_tgt_first, brs_tgt_second, brs_tgt_third} brs_target_e;
  typedef enum {brs_idle, brs_active} brs_state_e;
endpackage

// ===== logic/brs_regs.svh
// constants for the boot rom select and strobe block
// assumes 26-bit physical addresses from the core bus
`ifndef BRS_REGS_SVH
`define BRS_REGS_SVH
`define BRS_ADDR_W        26
`define BRS_BOOT_SEG      10'h3FF
`define BRS_ALIAS_SEG     10'h00F
`define BRS_SEG_LSB       16
`define BRS_HIGH_LO       26'h00A0000
`define BRS_HIGH_HI       26'h00FFFFF
`define BRS_WIDTH_32      2'h2
`define BRS_WIDTH_LSB     0
`define BRS_WIDTH_MSB     1
`define BRS_WIN_COUNT     4
`define BRS_PAGE_BITS     14
`define BRS_CLOCK_MHZ     100
`define BRS_SYNC_STAGES   3
`endif

// ===== logic/brs_rom_select.sv
// chip selects, strobes and wide buffer enable for boot and rom devices
// assumes one core access request per cycle, address and direction held while access_valid is high
`timescale 1ns/1ps
`include "brs_regs.svh"
module brs_rom_select
  import brs_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      nrst,
  input  wire logic                      access_valid,
  input  wire logic                      access_write,
  input  wire logic [`BRS_ADDR_W-1:0]    access_addr,
  input  wire logic [31:0]               write_data,
  output logic      [31:0]               read_data,
  input  wire logic [1:0]                boot_width_straps,
  input  wire logic                      width_from_setup,
  input  wire logic [1:0]                setup_width,
  input  wire logic                      alias_enable,
  input  wire logic                      high_mem_enable,
  input  wire logic [`BRS_WIN_COUNT-1:0] window_enable,
  input  wire logic [`BRS_WIN_COUNT*`BRS_PAGE_BITS-1:0] window_page,
  input  wire logic [`BRS_WIN_COUNT*2-1:0] window_target,
  input  wire logic                      third_select_enable,
  input  wire logic                      second_wide,
  input  wire logic                      third_wide,
  output logic      [2:0]                rom_selects,
  output logic                           rom_select_first,
  output logic                           rom_select_second,
  output logic                           rom_select_third,
  output logic                           rom_read_strobe,
  output logic                           rom_write_strobe,
  output logic                           rom_wide_buffer_oe,
  input  wire logic [31:0]               system_data_lines,
  output logic      [31:0]               system_data_lines_drive,
  output logic                           system_data_lines_oe_n
);
  logic [1:0]      strap_level;
  logic [1:0]      first_width;
  logic            first_wide;
  logic            alias_default;
  brs_target_e     next_target;
  brs_state_e      state;
  brs_state_e      next_state;

  brs_strap_sync u_strap_sync
  (
    .clock (clock),
    .nrst  (nrst),
    .pin   (boot_width_straps),
    .level (strap_level)
  );

  // window lookup; lowest numbered enabled window wins so only one target results
  function automatic brs_target_e window_lookup(input logic [`BRS_ADDR_W-1:0] addr,
                                                input logic [`BRS_WIN_COUNT-1:0] en,
                                                input logic [`BRS_WIN_COUNT*`BRS_PAGE_BITS-1:0] pg,
                                                input logic [`BRS_WIN_COUNT*2-1:0] tg);
    brs_target_e hit;
    hit = brs_tgt_none;
    for (int i = `BRS_WIN_COUNT - 1; i >= 0; i--)
      if (en[i] && (addr[`BRS_ADDR_W-1:`BRS_ADDR_W-`BRS_PAGE_BITS] == pg[i*`BRS_PAGE_BITS +: `BRS_PAGE_BITS]))
        hit = brs_target_e'(tg[i*2 +: 2]);
    return hit;
  endfunction

  // true for the first select whatever its width, or for a second or third device flagged 32 bits wide
  function automatic logic wide_device(input brs_target_e tgt, input logic sw, input logic tw);
    return (tgt == brs_tgt_first) || (tgt == brs_tgt_second && sw) || (tgt == brs_tgt_third && tw);
  endfunction

  assign first_width = width_from_setup ? setup_width : strap_level;
  assign first_wide  = (first_width == `BRS_WIDTH_32);

  // the alias decode is on by default only because the integrator ties alias_enable high
  assign alias_default = alias_enable;

  wire boot_hit  = (access_addr[`BRS_ADDR_W-1:`BRS_SEG_LSB] == `BRS_BOOT_SEG);
  wire alias_hit = alias_default && (access_addr[`BRS_ADDR_W-1:`BRS_SEG_LSB] == `BRS_ALIAS_SEG);
  wire high_hit  = high_mem_enable && (access_addr >= `BRS_HIGH_LO) && (access_addr <= `BRS_HIGH_HI);
  wire direct_hit = boot_hit || alias_hit || high_hit;
  brs_target_e win_tgt;
  assign win_tgt = window_lookup(access_addr, window_enable, window_page, window_target);

  // windows take priority over direct decode, except a third window while third_select_enable is low; second and third only from windows
  always_comb
  begin
    next_target = brs_tgt_none;
    if (access_valid)
    begin
      if (win_tgt == brs_tgt_first)
        next_target = brs_tgt_first;
      else if (win_tgt == brs_tgt_second)
        next_target = brs_tgt_second;
      else if (win_tgt == brs_tgt_third && third_select_enable)
        next_target = brs_tgt_third;
      else if (direct_hit)
        next_target = brs_tgt_first;
    end
  end

  assign next_state = (next_target != brs_tgt_none) ? brs_active : brs_idle;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state  <= brs_idle;
    end
    else
    begin
      state  <= next_state;
    end
  end

  wire active    = (state == brs_active);
  // a second or third device only widens the buffer once the first region itself is wide
  wire next_wide = first_wide && (next_state == brs_active) && wide_device(next_target, second_wide, third_wide);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rom_selects        <= 3'h7;
      rom_read_strobe    <= 1'b0;
      rom_write_strobe   <= 1'b0;
      rom_wide_buffer_oe <= 1'b0;
    end
    else
    begin
      rom_selects[0]     <= !(next_target == brs_tgt_first);
      rom_selects[1]     <= !(next_target == brs_tgt_second);
      rom_selects[2]     <= !(next_target == brs_tgt_third);
      rom_read_strobe    <= (next_state == brs_active) && !access_write;
      rom_write_strobe   <= (next_state == brs_active) && access_write;
      rom_wide_buffer_oe <= next_wide;
    end
  end

  assign rom_select_first  = rom_selects[0];
  assign rom_select_second = rom_selects[1];
  assign rom_select_third  = rom_selects[2];

  // shared data lines: driven only on writes, captured on reads
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      system_data_lines_drive <= 32'h0;
      system_data_lines_oe_n <= 1'b1;
      read_data              <= 32'h0;
    end
    else
    begin
      system_data_lines_drive <= write_data;
      system_data_lines_oe_n  <= !((next_state == brs_active) && access_write);
      if (active && rom_read_strobe)
        read_data <= system_data_lines;
    end
  end


  // select and strobe checks; outputs lag the decode by one edge
  a_one_strobe: assert property (@(posedge clock) disable iff (!nrst)
    !(rom_read_strobe && rom_write_strobe))
    else $error("both strobes high");
  a_one_select: assert property (@(posedge clock) disable iff (!nrst)
    $countones(~rom_selects) <= 1)
    else $error("more than one select");
  a_boot_decode: assert property (@(posedge clock) disable iff (!nrst)
    access_valid && win_tgt == brs_tgt_none && boot_hit |=> !rom_select_first)
    else $error("boot miss");
  a_alias_decode: assert property (@(posedge clock) disable iff (!nrst)
    access_valid && win_tgt == brs_tgt_none && alias_hit |=> !rom_select_first)
    else $error("alias miss");
  a_high_decode: assert property (@(posedge clock) disable iff (!nrst)
    access_valid && win_tgt == brs_tgt_none && high_hit |=> !rom_select_first)
    else $error("high memory miss");
  a_first_window: assert property (@(posedge clock) disable iff (!nrst)
    access_valid && win_tgt == brs_tgt_first |=> !rom_select_first)
    else $error("first window miss");
  a_second_window: assert property (@(posedge clock) disable iff (!nrst)
    !rom_select_second |-> $past(win_tgt) == brs_tgt_second)
    else $error("second not from window");
  a_third_gated: assert property (@(posedge clock) disable iff (!nrst)
    !rom_select_third |-> $past(third_select_enable) && $past(win_tgt) == brs_tgt_third)
    else $error("third bad");
  a_idle_quiet: assert property (@(posedge clock) disable iff (!nrst)
    !access_valid |=> rom_selects == 3'h7 && !rom_read_strobe && !rom_write_strobe && !rom_wide_buffer_oe)
    else $error("outputs active while idle");

  sequence s_read_req;
    access_valid && !access_write && next_target != brs_tgt_none;
  endsequence
  a_read_strobe: assert property (@(posedge clock) disable iff (!nrst)
    s_read_req |=> rom_read_strobe && !rom_write_strobe)
    else $error("read strobe missing");
  a_write_strobe: assert property (@(posedge clock) disable iff (!nrst)
    access_valid && access_write && next_target != brs_tgt_none |=> rom_write_strobe && !system_data_lines_oe_n)
    else $error("write strobe missing");
  a_read_capture: assert property (@(posedge clock) disable iff (!nrst)
    rom_read_strobe |=> read_data == $past(system_data_lines))
    else $error("read data not captured");
  a_wide_first: assert property (@(posedge clock) disable iff (!nrst)
    first_wide && next_target == brs_tgt_first |=> rom_wide_buffer_oe)
    else $error("wide oe missing");
  a_wide_needs: assert property (@(posedge clock) disable iff (!nrst)
    rom_wide_buffer_oe |-> $past(first_wide) && $past(next_state) == brs_active &&
                           $past(wide_device(next_target, second_wide, third_wide)))
    else $error("wide oe spurious");
endmodule

// ===== logic/brs_strap_sync.sv
// three-stage synchroniser for the boot-width strap pins
// assumes straps are static pins outside the clock domain
`timescale 1ns/1ps
`include "brs_regs.svh"
module brs_strap_sync
  import brs_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [1:0] pin,
  output logic      [1:0] level
);
  logic [1:0] stage1;
  logic [1:0] stage2;
  logic [1:0] stage3;
  wire        agree = (stage2 == stage3);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1 <= 2'h0;
      stage2 <= 2'h0;
      stage3 <= 2'h0;
      level  <= 2'h0;
    end
    else
    begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      if (agree)
        level <= stage3;
    end
  end
endmodule

// ===== test/brs_rom_model.sv
// behavioural rom/flash devices behind the three selects, one word each
// assumes active-low selects and active-high strobes from the block
`timescale 1ns/1ps
module brs_rom_model
(
  input  wire logic        clock,
  input  wire logic [2:0]  rom_selects,
  input  wire logic        rom_read_strobe,
  input  wire logic        rom_write_strobe,
  input  wire logic [31:0] bus_from_host,
  output logic      [31:0] bus_to_host
);
  logic [31:0] mem [3] = '{32'h0, 32'h0, 32'h0};
  logic [31:0] last = 32'h0;
  logic        hit;
  int          k;
  always_comb
  begin
    hit = 1'b0;
    k = 0;
    for (int i = 0; i < 3; i++)
      if (!rom_selects[i])
      begin
        hit = 1'b1;
        k = i;
      end
  end
  // a released bus toggles so a stale word never passes for a good read
  assign bus_to_host = (hit && rom_read_strobe) ? mem[k] : ~last;
  always @(posedge clock)
  begin
    last <= bus_to_host;
    if (hit && rom_write_strobe)
      mem[k] <= bus_from_host;
  end
endmodule

// ===== test/brs_rom_select_tb.sv
// self-checking bench for the rom select block with a rom model on the data lines
// assumes registered outputs one cycle after the access edge, straps settle within 8 cycles
`timescale 1ns/1ps
module brs_rom_select_tb;
  import brs_pkg::*;
  typedef struct {logic [2:0] sel; logic rd; logic wr; logic oe; logic [31:0] rdata;} brs_note_s;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        access_valid = 1'b0, access_write = 1'b0, width_from_setup = 1'b0, alias_enable = 1'b1;
  logic        high_mem_enable = 1'b1, third_select_enable = 1'b1, second_wide = 1'b0, third_wide = 1'b0;
  logic [25:0] access_addr = 26'h0;
  logic [31:0] write_data = 32'h0, read_data, bus_in, bus_out, seed = 32'h0000EDEB;
  logic [1:0]  boot_width_straps = 2'h2, setup_width = 2'h0;
  logic [3:0]  window_enable = 4'h7;
  logic [55:0] window_page = {14'h0300, 14'h0300, 14'h0200, 14'h0100};
  logic [7:0]  window_target = 8'h39;
  logic [2:0]  rom_selects;
  logic        sel_a, sel_b, sel_c, rd_s, wr_s, wide_oe, bus_oe_n;
  logic [31:0] shadow [4] = '{32'h0, 32'h0, 32'h0, 32'h0};
  brs_note_s   notes [$];
  brs_note_s   cur;
  int          n_fail = 0, n_compared = 0, cycles = 0;
  always #5 clock = ~clock;
  brs_rom_select dut (.clock(clock), .nrst(nrst), .access_valid(access_valid), .access_write(access_write),
    .access_addr(access_addr), .write_data(write_data), .read_data(read_data),
    .boot_width_straps(boot_width_straps), .width_from_setup(width_from_setup), .setup_width(setup_width),
    .alias_enable(alias_enable), .high_mem_enable(high_mem_enable), .window_enable(window_enable),
    .window_page(window_page), .window_target(window_target),
    .third_select_enable(third_select_enable), .second_wide(second_wide), .third_wide(third_wide),
    .rom_selects(rom_selects), .rom_select_first(sel_a), .rom_select_second(sel_b), .rom_select_third(sel_c),
    .rom_read_strobe(rd_s), .rom_write_strobe(wr_s), .rom_wide_buffer_oe(wide_oe),
    .system_data_lines(bus_in), .system_data_lines_drive(bus_out), .system_data_lines_oe_n(bus_oe_n));
  brs_rom_model rom (.clock(clock), .rom_selects(rom_selects), .rom_read_strobe(rd_s),
    .rom_write_strobe(wr_s), .bus_from_host(bus_out), .bus_to_host(bus_in));
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task conclude;
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // t is the expected select (0 none), oe the expected wide buffer enable
  task automatic acc(input logic [25:0] a, input logic w, input int t, input logic oe);
    brs_note_s n;
    @(negedge clock);
    access_addr = a;
    access_write = w;
    write_data = rnd();
    access_valid = 1'b1;
    if (t != 0)
    begin
      n = '{~(3'h1 << (t - 1)), !w, w, oe, shadow[t]};
      notes.push_back(n);
      if (w)
        shadow[t] = write_data;
    end
    @(negedge clock);
    access_valid = 1'b0;
  endtask
  always @(negedge clock)
    if (nrst && (rom_selects !== 3'h7 || rd_s !== 1'b0 || wr_s !== 1'b0 || wide_oe !== 1'b0 || bus_oe_n !== 1'b1))
    begin
      if (notes.size() == 0)
        chk("idle_outputs", 32'h71, 32'({rom_selects, rd_s, wr_s, wide_oe, bus_oe_n}));
      else
      begin
        cur = notes.pop_front();
        chk("rom_selects", 32'(cur.sel), 32'(rom_selects));
        chk("select_copies", 32'(cur.sel), 32'({sel_c, sel_b, sel_a}));
        chk("strobes", 32'({cur.rd, cur.wr}), 32'({rd_s, wr_s}));
        chk("wide_oe", 32'(cur.oe), 32'(wide_oe));
        chk("bus_oe_n", 32'(!cur.wr), 32'(bus_oe_n));
        if (cur.rd)
        begin
          @(negedge clock);
          chk("read_data", cur.rdata, read_data);
        end
      end
    end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_fail++;
      conclude();
    end
  end
  initial
  begin
    logic [15:0] off;
    repeat (16) @(posedge clock);
    @(negedge clock);
    nrst = 1'b1;
    repeat (8) @(negedge clock);
    for (int i = 0; i < 6; i++)
    begin
      off = 16'(rnd());
      second_wide = off[0];
      third_wide = off[1];
      acc({10'h3FF, off}, 1'b0, 1, 1'b1);
      acc({10'h00F, off}, 1'b0, 1, 1'b1);
      acc(26'h00A0000 + off, 1'b0, 1, 1'b1);
      acc(26'h0100000 | off[11:0], off[2], 1, 1'b1);
      acc(26'h0100000, 1'b0, 1, 1'b1);
      acc(26'h0200000 | off[11:0], off[3], 2, second_wide);
      acc(26'h0300000 | off[11:0], off[4], 3, third_wide);
    end
    // reset mid-run: outputs drop at once and the straps resynchronise before the next access
    @(negedge clock);
    nrst = 1'b0;
    @(negedge clock);
    chk("reset_outputs", 32'h71, 32'({rom_selects, rd_s, wr_s, wide_oe, bus_oe_n}));
    chk("reset_read_data", 32'h0, read_data);
    nrst = 1'b1;
    repeat (8) @(negedge clock);
    third_select_enable = 1'b0;
    acc(26'h0300010, 1'b0, 0, 1'b0);
    high_mem_enable = 1'b0;
    alias_enable = 1'b0;
    window_enable = 4'h5;
    acc(26'h00A1234, 1'b0, 0, 1'b0);
    acc(26'h00FFFF0, 1'b0, 0, 1'b0);
    acc(26'h0200040, 1'b0, 0, 1'b0);
    // two windows on one page: the lower index wins even when its select is unavailable
    window_target = 8'hB9;
    window_enable = 4'hD;
    acc(26'h0300020, 1'b0, 0, 1'b0);
    window_enable = 4'h8;
    acc(26'h0300030, 1'b1, 2, second_wide);
    width_from_setup = 1'b1;
    setup_width = 2'h1;
    repeat (2) @(negedge clock);
    acc(26'h3FFFFF0, 1'b0, 1, 1'b0);
    setup_width = 2'h2;
    acc(26'h3FF0004, 1'b0, 1, 1'b1);
    width_from_setup = 1'b0;
    boot_width_straps = 2'h0;
    repeat (8) @(negedge clock);
    acc(26'h3FF0008, 1'b1, 1, 1'b0);
    repeat (3) @(negedge clock);
    chk("pending_notes", 32'h0, 32'(notes.size()));
    conclude();
  end
endmodule
